/* File: ctt_regs.svh */
`ifndef CTT_REGS_SVH
`define CTT_REGS_SVH
// Summary of operation
// - Mode selector takes 0 to 3 and resets to 1.
// - A new mode becomes active only at the next power-on load.
// - Mode 0 switches the second axis off, leaving a single axis.
// - Mode 1 is setpoint operation: speed, torque or torque reduction.
// - Mode 2 is external position reference, deprecated, not relied upon.
// - Mode 3 is positioning with stored traversing blocks.
// - Positioning blocks are freely configurable by software.
// - Current loop period is 2 to 4 base ticks, default 4, at power-on.
// - Speed loop period is 2 to 16 base ticks, default 4, at power-on.
// - Position loop period is 32 to 128 ticks, default 32, at power-on.
// - Interpolation period is 64 to 640 ticks, default 128, at power-on.
// - All loop periods are whole counts of a 31.25 us base tick.
// - Two active axes share identical period settings for every loop.
// - Two axes in positioning reject a 62.5 us current period.
// - The high resolution board variant permits that 62.5 us period.
// - Speed loop period is never shorter than current loop period.
// - Two active axes reject a 62.5 us speed loop period.
// - Position loop period is a whole multiple of speed loop period.
// - Interpolation period is a whole multiple of position period.

// Register byte offsets.
`define CTT_OFS_MODE   6'h00
`define CTT_OFS_CUR    6'h04
`define CTT_OFS_SPD    6'h08
`define CTT_OFS_POS    6'h0c
`define CTT_OFS_IPO    6'h10
`define CTT_OFS_CTRL   6'h14
`define CTT_OFS_STAT   6'h18
`define CTT_OFS_CMD    6'h1c

// Mode values, reset values and legal ranges.
`define CTT_MODE_RST    16'h0001
`define CTT_MODE_MAX    16'h0003
`define CTT_MODE_SINGLE 2'h0
`define CTT_MODE_SETPT  2'h1
`define CTT_MODE_EXTPOS 2'h2
`define CTT_MODE_POSN   2'h3
`define CTT_CUR_RST     16'h0004
`define CTT_CUR_MIN     16'h0002
`define CTT_CUR_MAX     16'h0004
`define CTT_SPD_RST     16'h0004
`define CTT_SPD_MIN     16'h0002
`define CTT_SPD_MAX     16'h0010
`define CTT_POS_RST     16'h0020
`define CTT_POS_MIN     16'h0020
`define CTT_POS_MAX     16'h0080
`define CTT_IPO_RST     16'h0080
`define CTT_IPO_MIN     16'h0040
`define CTT_IPO_MAX     16'h0280
`define CTT_FAST_PERIOD 16'h0002

// Base tick time and its length in clock cycles.
`define CTT_BASE_TICK_US 31.25
`define CTT_CLK_MHZ      100
`define CTT_BASE_CYCLES  (`CTT_BASE_TICK_US * `CTT_CLK_MHZ)

// Control, command and status bit positions.
`define CTT_CTRL_COMM    0
`define CTT_CMD_RECALC   0
`define CTT_ST_MODE_LSB  0
`define CTT_ST_TWO_AXIS  2
`define CTT_ST_REJECT    3
`define CTT_ST_DEPREC    4
`define CTT_ST_WHY_LSB   8
`define CTT_WHY_CUR      0
`define CTT_WHY_SPD      1
`define CTT_WHY_POS      2
`define CTT_WHY_IPO      3
`define CTT_WHY_ORDER    4
`define CTT_WHY_POS_MUL  5
`define CTT_WHY_IPO_MUL  6
`define CTT_WHY_AXES     7
`endif

/* File: ctt_pkg.sv */
`default_nettype none
package ctt_pkg;

    typedef enum logic {CTT_BUS_IDLE, CTT_BUS_ANSWER} ctt_bus_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } ctt_div_s;

    typedef struct packed {
        ctt_bus_e    bus;
        logic        waitreq;
        logic [31:0] rdata;
        logic [15:0] mode;
        logic [15:0] cur;
        logic [15:0] spd;
        logic [15:0] pos;
        logic [15:0] ipo;
        logic        comm_en;
        logic        recalc;
        logic [1:0]  act_mode;
        logic [15:0] a_cur;
        logic [15:0] a_spd;
        logic [15:0] a_pos;
        logic [15:0] a_ipo;
        logic        two_axis;
        logic        hres_act;
        logic        reject;
        logic [7:0]  why;
        logic        comm_out;
        logic [1:0]  dual_sync;
        logic [1:0]  hres_sync;
        logic [2:0]  load_sync;
        logic [15:0] base_cnt;
        logic        base_tick;
        logic        restart;
    } ctt_state_s;

endpackage
`default_nettype wire

/* File: ctt_loop_div.sv */
`default_nettype none
module ctt_loop_div (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        base_tick,
    input  wire logic        restart,
    input  wire logic [15:0] period,
    output logic             tick
);

    ctt_pkg::ctt_div_s s;
    ctt_pkg::ctt_div_s next_s;

    // Counts base ticks; a restart lines every divider up on the same edge.
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (restart) begin
            next_s.cnt = 16'h0000;
        end else if (base_tick) begin
            if (s.cnt >= period - 16'h0001) begin
                next_s.cnt = 16'h0000;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule
`default_nettype wire

/* File: ctt_timebase.sv */
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`default_nettype none
`include "ctt_regs.svh"
module ctt_timebase #(
    parameter int BASE_CYCLES = int'(`CTT_BASE_CYCLES)
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        dual_axis_board,
    input  wire logic        high_resolution_board_variant,
    input  wire logic        power_on_load,
    output logic [1:0]       active_mode,
    output logic             second_axis_active,
    output logic             second_drive_comm_enable,
    output logic             recalc_controller_data_cmd,
    output logic             config_rejected,
    output logic             tick_current,
    output logic             tick_speed,
    output logic             tick_position,
    output logic             tick_interp
);

    localparam logic [15:0] BASE_LAST = 16'(BASE_CYCLES - 1);

    ctt_pkg::ctt_state_s s;
    ctt_pkg::ctt_state_s next_s;
    logic                load_go;
    logic                dual;
    logic [7:0]          why_now;
    logic [3:0]          ticks;
    logic [3:0][15:0]    periods;

    // Merges the two low byte lanes into a 16-bit register.
    function automatic logic [15:0] be_merge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Checks a period set; each set bit names one broken restriction.
    function automatic logic [7:0] period_check(
        input logic [15:0] cur,
        input logic [15:0] spd,
        input logic [15:0] pos,
        input logic [15:0] ipo,
        input logic        two,
        input logic        posn,
        input logic        hres
    );
        logic [7:0] w;
        w = 8'h00;
        w[`CTT_WHY_CUR] = cur < `CTT_CUR_MIN || cur > `CTT_CUR_MAX;
        w[`CTT_WHY_SPD] = spd < `CTT_SPD_MIN || spd > `CTT_SPD_MAX;
        w[`CTT_WHY_POS] = pos < `CTT_POS_MIN || pos > `CTT_POS_MAX;
        w[`CTT_WHY_IPO] = ipo < `CTT_IPO_MIN || ipo > `CTT_IPO_MAX;
        w[`CTT_WHY_ORDER] = spd < cur;
        // Division only happens when the divisor is in range, never by zero.
        if (!w[`CTT_WHY_SPD] && !w[`CTT_WHY_POS]) begin
            w[`CTT_WHY_POS_MUL] = (pos % spd) != 16'h0000;
        end
        if (!w[`CTT_WHY_POS] && !w[`CTT_WHY_IPO]) begin
            w[`CTT_WHY_IPO_MUL] = (ipo % pos) != 16'h0000;
        end
        // Two axes load the CPU twice, so the fastest speed cycle is barred, and the fastest current cycle in positioning without high resolution.
        if (two && spd == `CTT_FAST_PERIOD) begin
            w[`CTT_WHY_AXES] = 1'b1;
        end
        if (two && posn && !hres && cur == `CTT_FAST_PERIOD) begin
            w[`CTT_WHY_AXES] = 1'b1;
        end
        return w;
    endfunction

    // Read multiplexer; unmapped addresses read as zero.
    function automatic logic [31:0] read_mux(
        input ctt_pkg::ctt_state_s st,
        input logic [5:0]          a
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a[5:2] == `CTT_OFS_MODE >> 2) begin
            r[15:0] = st.mode;
        end else if (a[5:2] == `CTT_OFS_CUR >> 2) begin
            r[15:0] = st.cur;
        end else if (a[5:2] == `CTT_OFS_SPD >> 2) begin
            r[15:0] = st.spd;
        end else if (a[5:2] == `CTT_OFS_POS >> 2) begin
            r[15:0] = st.pos;
        end else if (a[5:2] == `CTT_OFS_IPO >> 2) begin
            r[15:0] = st.ipo;
        end else if (a[5:2] == `CTT_OFS_CTRL >> 2) begin
            r[`CTT_CTRL_COMM] = st.comm_en;
        end else if (a[5:2] == `CTT_OFS_STAT >> 2) begin
            r[`CTT_ST_MODE_LSB +: 2] = st.act_mode;
            r[`CTT_ST_TWO_AXIS] = st.two_axis;
            r[`CTT_ST_REJECT] = st.reject;
            r[`CTT_ST_DEPREC] = st.act_mode == `CTT_MODE_EXTPOS;
            r[`CTT_ST_WHY_LSB +: 8] = st.why;
        end
        return r;
    endfunction

    // Second synchroniser stages, plus the third load stage for edge detection; the first stages feed nothing else.
    assign dual = s.dual_sync[1];
    assign load_go = s.load_sync[1] & ~s.load_sync[2];
    assign why_now = period_check(s.cur, s.spd, s.pos, s.ipo,
                                  dual && s.mode != 16'h0000,
                                  s.mode[1:0] == `CTT_MODE_POSN,
                                  s.hres_sync[1]);

    // Next-state logic for bus, staged settings, active settings and ticks.
    always_comb begin
        next_s = s;
        next_s.recalc = 1'b0;
        next_s.restart = 1'b0;
        next_s.dual_sync = {s.dual_sync[0], dual_axis_board};
        next_s.hres_sync = {s.hres_sync[0], high_resolution_board_variant};
        next_s.load_sync = {s.load_sync[1:0], power_on_load};
        // One shared base counter drives every loop divider.
        if (s.base_cnt >= BASE_LAST) begin
            next_s.base_cnt = 16'h0000;
            next_s.base_tick = 1'b1;
        end else begin
            next_s.base_cnt = s.base_cnt + 16'h0001;
            next_s.base_tick = 1'b0;
        end
        // One wait cycle: answer prepared first, committed on the next edge.
        case (s.bus)
            ctt_pkg::CTT_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_s.bus = ctt_pkg::CTT_BUS_ANSWER;
                    next_s.waitreq = 1'b0;
                    next_s.rdata = avs_read ? read_mux(s, avs_address)
                                            : 32'h0000_0000;
                end
            end
            ctt_pkg::CTT_BUS_ANSWER: begin
                next_s.bus = ctt_pkg::CTT_BUS_IDLE;
                next_s.waitreq = 1'b1;
                if (avs_write) begin
                    if (avs_address[5:2] == `CTT_OFS_MODE >> 2) begin
                        // Out-of-range mode values are dropped whole.
                        if (be_merge(s.mode, avs_writedata, avs_byteenable)
                            <= `CTT_MODE_MAX) begin
                            next_s.mode = be_merge(s.mode, avs_writedata,
                                                   avs_byteenable);
                        end
                    end else if (avs_address[5:2] == `CTT_OFS_CUR >> 2) begin
                        next_s.cur = be_merge(s.cur, avs_writedata,
                                              avs_byteenable);
                    end else if (avs_address[5:2] == `CTT_OFS_SPD >> 2) begin
                        next_s.spd = be_merge(s.spd, avs_writedata,
                                              avs_byteenable);
                    end else if (avs_address[5:2] == `CTT_OFS_POS >> 2) begin
                        next_s.pos = be_merge(s.pos, avs_writedata,
                                              avs_byteenable);
                    end else if (avs_address[5:2] == `CTT_OFS_IPO >> 2) begin
                        next_s.ipo = be_merge(s.ipo, avs_writedata,
                                              avs_byteenable);
                    end else if (avs_address[5:2] == `CTT_OFS_CTRL >> 2) begin
                        if (avs_byteenable[0]) begin
                            next_s.comm_en = avs_writedata[`CTT_CTRL_COMM];
                        end
                    end else if (avs_address[5:2] == `CTT_OFS_CMD >> 2) begin
                        if (avs_byteenable[0]) begin
                            next_s.recalc = avs_writedata[`CTT_CMD_RECALC];
                        end
                    end
                end
            end
            default: begin
                next_s.bus = ctt_pkg::CTT_BUS_IDLE;
                next_s.waitreq = 1'b1;
            end
        endcase
        // The active set changes only at a power-on load, never in between.
        if (load_go) begin
            next_s.act_mode = s.mode[1:0];
            next_s.two_axis = dual && s.mode != 16'h0000;
            next_s.hres_act = s.hres_sync[1];
            next_s.why = why_now;
            next_s.reject = why_now != 8'h00;
            // One period set serves both axes, so they can never differ.
            if (why_now == 8'h00) begin
                next_s.a_cur = s.cur;
                next_s.a_spd = s.spd;
                next_s.a_pos = s.pos;
                next_s.a_ipo = s.ipo;
            end else begin
                next_s.a_cur = `CTT_CUR_RST;
                next_s.a_spd = `CTT_SPD_RST;
                next_s.a_pos = `CTT_POS_RST;
                next_s.a_ipo = `CTT_IPO_RST;
            end
            next_s.base_cnt = 16'h0000;
            next_s.base_tick = 1'b0;
            next_s.restart = 1'b1;
        end
        // An inactive second axis is kept silent here by gating comm_en with two_axis.
        next_s.comm_out = s.two_axis & s.comm_en;
    end

    // State register with synchronous power-on defaults.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= '{bus: ctt_pkg::CTT_BUS_IDLE, waitreq: 1'b1,
                   mode: `CTT_MODE_RST, cur: `CTT_CUR_RST,
                   spd: `CTT_SPD_RST, pos: `CTT_POS_RST,
                   ipo: `CTT_IPO_RST, comm_en: 1'b1,
                   act_mode: `CTT_MODE_SETPT, a_cur: `CTT_CUR_RST,
                   a_spd: `CTT_SPD_RST, a_pos: `CTT_POS_RST,
                   a_ipo: `CTT_IPO_RST, default: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Four dividers, listed slowest first, index 0 the fastest.
    assign periods = {s.a_ipo, s.a_pos, s.a_spd, s.a_cur};
    generate
        for (genvar i = 0; i < 4; i++) begin : g_div
            ctt_loop_div u_div (
                .clock     (clock),
                .nrst      (nrst),
                .ce        (ce),
                .base_tick (s.base_tick),
                .restart   (s.restart),
                .period    (periods[i]),
                .tick      (ticks[i])
            );
        end
    endgenerate

    // Outputs come straight from flip-flops.
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign active_mode = s.act_mode;
    assign second_axis_active = s.two_axis;
    assign second_drive_comm_enable = s.comm_out;
    assign recalc_controller_data_cmd = s.recalc;
    assign config_rejected = s.reject;
    assign tick_current = ticks[0];
    assign tick_speed = ticks[1];
    assign tick_position = ticks[2];
    assign tick_interp = ticks[3];

    // Checks; positioning blocks live in firmware, the mode flag gates them.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_recalc_wr;
        ce && s.bus == ctt_pkg::CTT_BUS_ANSWER && avs_write &&
        avs_address[5:2] == (`CTT_OFS_CMD >> 2) && avs_byteenable[0] &&
        avs_writedata[`CTT_CMD_RECALC];
    endsequence
    sequence s_pulse_once;
        recalc_controller_data_cmd ##1 (!ce || !recalc_controller_data_cmd);
    endsequence
    sequence s_bad_load;
        ce && load_go && why_now != 8'h00;
    endsequence

    property p_mode_range;
        s.mode <= `CTT_MODE_MAX;
    endproperty
    a_mode_range: assert property (p_mode_range)
        else $error("staged mode left its range");

    property p_mode_frozen;
        !load_go |=> $stable(active_mode);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("active mode changed without a power-on load");

    property p_single_axis;
        active_mode == `CTT_MODE_SINGLE |-> !second_axis_active;
    endproperty
    a_single_axis: assert property (p_single_axis)
        else $error("second axis active in single axis mode");

    property p_reject_default;
        s_bad_load |=> config_rejected && s.a_cur == `CTT_CUR_RST &&
            s.a_spd == `CTT_SPD_RST && s.a_pos == `CTT_POS_RST &&
            s.a_ipo == `CTT_IPO_RST;
    endproperty
    a_reject_default: assert property (p_reject_default)
        else $error("rejected set did not fall back to defaults");

    property p_order;
        s.a_spd >= s.a_cur;
    endproperty
    a_order: assert property (p_order)
        else $error("speed period shorter than current period");

    property p_multiples;
        (s.a_pos % s.a_spd) == 16'h0000 && (s.a_ipo % s.a_pos) == 16'h0000;
    endproperty
    a_multiples: assert property (p_multiples)
        else $error("active periods are not whole multiples");

    property p_two_axis_fast;
        s.two_axis |-> s.a_spd != `CTT_FAST_PERIOD &&
            (s.a_cur != `CTT_FAST_PERIOD || s.hres_act ||
             s.act_mode != `CTT_MODE_POSN);
    endproperty
    a_two_axis_fast: assert property (p_two_axis_fast)
        else $error("fast period active with two axes");

    property p_recalc;
        s_recalc_wr |=> s_pulse_once;
    endproperty
    a_recalc: assert property (p_recalc)
        else $error("recalc command is not a single pulse");

    property p_nested;
        tick_interp |-> tick_position && tick_speed;
    endproperty
    a_nested: assert property (p_nested)
        else $error("slow tick without the faster ticks");

    property p_bus_answer;
        ce && (avs_read || avs_write) && s.bus == ctt_pkg::CTT_BUS_IDLE
            |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not given after one wait cycle");

endmodule
`default_nettype wire

/* File: control_cycle_timebase_test.sv */
`default_nettype none
module control_cycle_timebase_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        hres = 1'b0;
    logic        power_on_load = 1'b0;
    logic [1:0]  active_mode;
    logic        two_ax;
    logic        comm_en;
    logic        recalc;
    logic        config_rejected;
    logic [3:0]  ticks;
    logic [31:0] rd;
    logic [31:0] rst_v [6] = '{32'h1, 32'h4, 32'h4, 32'h20, 32'h80, 32'h1};
    int          miscompares = 0;
    int          check_count = 0;
    int          recalc_seen = 0;

    // A short base tick keeps the longest period at a few hundred cycles.
    ctt_timebase #(.BASE_CYCLES(4)) dut_u (
        .clock(clock), .nrst(nrst), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hf),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dual_axis_board(1'b1),
        .high_resolution_board_variant(hres),
        .power_on_load(power_on_load), .active_mode(active_mode),
        .second_axis_active(two_ax), .second_drive_comm_enable(comm_en),
        .recalc_controller_data_cmd(recalc),
        .config_rejected(config_rejected), .tick_current(ticks[0]),
        .tick_speed(ticks[1]), .tick_position(ticks[2]),
        .tick_interp(ticks[3]));

    // The clock runs at 100 MHz.
    always #5 clock = ~clock;

    // Slower ticks must land on faster ones; recalc pulses are counted.
    always @(posedge clock) begin
        if (nrst === 1'b1 && ((ticks[3] && !ticks[2]) ||
            (ticks[2] && !ticks[1]) || (ticks[1] && !ticks[0]))) begin
            miscompares++;
            $display("[ERR] tick nesting expected aligned seen %b", ticks);
        end
        if (recalc === 1'b1) begin
            recalc_seen++;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Outputs are registered, so values read at the edge are the sampled ones.
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [5:0] a,
                        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // The pin is held long enough on both levels to pass the synchroniser.
    task automatic load();
        @(posedge clock);
        power_on_load <= 1'b1;
        repeat (5) @(posedge clock);
        power_on_load <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic cfg(input logic [1:0] m, input logic [15:0] c, s, p, i,
                       input logic h, input logic [7:0] why);
        bus(1'b1, 6'h00, {30'h0, m});
        bus(1'b1, 6'h04, {16'h0, c});
        bus(1'b1, 6'h08, {16'h0, s});
        bus(1'b1, 6'h0c, {16'h0, p});
        bus(1'b1, 6'h10, {16'h0, i});
        hres <= h;
        load();
        rchk("status", 6'h18, {16'h0, why, 3'h0, m == 2'h2, why != 8'h0,
             m != 2'h0, m});
        chk("active_mode", {30'h0, m}, {30'h0, active_mode});
        chk("second_axis_active", {31'h0, m != 2'h0}, {31'h0, two_ax});
        chk("config_rejected", {31'h0, why != 8'h0},
            {31'h0, config_rejected});
    endtask

    // Counts the cycles between two pulses of one tick.
    task automatic gap(input int k, input int exp);
        int n;
        n = 0;
        while (ticks[k] !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ticks[k] !== 1'b1 && n < 3000);
        chk("tick gap", exp, n);
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the few thousand cycles needed.
    initial begin
        #400000;
        miscompares++;
        $display("[ERR] run expected done seen timeout");
        tally_and_finish();
    end

    // Main sequence of register accesses and power-on loads.
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        for (int k = 0; k < 6; k++) begin
            rchk("reset value", 6'(4 * k), rst_v[k]);
        end
        chk("active_mode", 32'h1, {30'h0, active_mode});
        bus(1'b1, 6'h24, 32'h5);
        rchk("unmapped", 6'h24, 32'h0);
        gap(0, 16);
        gap(1, 16);
        gap(2, 128);
        gap(3, 512);
        bus(1'b1, 6'h00, 32'h3);
        bus(1'b1, 6'h00, 32'h4);
        rchk("mode", 6'h00, 32'h3);
        chk("active_mode", 32'h1, {30'h0, active_mode});
        cfg(2'h3, 16'h4, 16'h4, 16'h20, 16'h80, 1'b0, 8'h00);
        cfg(2'h2, 16'h4, 16'h4, 16'h20, 16'h80, 1'b0, 8'h00);
        cfg(2'h0, 16'h4, 16'h2, 16'h20, 16'h80, 1'b0, 8'h10);
        cfg(2'h0, 16'h2, 16'h2, 16'h20, 16'h80, 1'b0, 8'h00);
        cfg(2'h1, 16'h4, 16'h1, 16'h20, 16'h80, 1'b0, 8'h12);
        cfg(2'h1, 16'h4, 16'h4, 16'h10, 16'h80, 1'b0, 8'h04);
        cfg(2'h1, 16'h4, 16'h4, 16'h20, 16'h300, 1'b0, 8'h08);
        cfg(2'h1, 16'h4, 16'h8, 16'h24, 16'h90, 1'b0, 8'h20);
        cfg(2'h1, 16'h4, 16'h4, 16'h20, 16'h50, 1'b0, 8'h40);
        cfg(2'h1, 16'h2, 16'h2, 16'h20, 16'h80, 1'b0, 8'h80);
        cfg(2'h3, 16'h2, 16'h4, 16'h20, 16'h80, 1'b0, 8'h80);
        cfg(2'h3, 16'h2, 16'h4, 16'h20, 16'h80, 1'b1, 8'h00);
        cfg(2'h1, 16'h2, 16'h4, 16'h20, 16'h40, 1'b0, 8'h00);
        gap(0, 8);
        gap(1, 16);
        gap(2, 128);
        gap(3, 256);
        chk("comm enable", 32'h1, {31'h0, comm_en});
        bus(1'b1, 6'h14, 32'h0);
        repeat (2) @(posedge clock);
        chk("comm enable", 32'h0, {31'h0, comm_en});
        bus(1'b1, 6'h1c, 32'h1);
        repeat (3) @(posedge clock);
        chk("recalc pulses", 32'h1, recalc_seen);
        bus(1'b1, 6'h1c, 32'h0);
        repeat (3) @(posedge clock);
        chk("recalc pulses", 32'h1, recalc_seen);
        cfg(2'h1, 16'h1, 16'h4, 16'h20, 16'h80, 1'b0, 8'h01);
        gap(0, 16);
        tally_and_finish();
    end
endmodule
`default_nettype wire
